// [rtl/port_a_io_map.vh]
`ifndef PORT_A_IO_MAP_VH
`define PORT_A_IO_MAP_VH
// Register byte offsets
`define OFF_PIN_LEVELS     12'h000
`define OFF_OUTPUT_LATCH   12'h004
`define OFF_DIRECTION      12'h008
`define OFF_ANALOG_SELECT  12'h00c
`define OFF_STEERING       12'h010
`define OFF_PERIPH_ENABLE  12'h014
// Steering field positions
`define BIT_OSC_SEL        0
`define BIT_LOGIC_SEL      1
`define BIT_TGATE_SEL      3
`define BIT_SS_SEL         4
`define BIT_SDO_SEL        5
`define STEER_MASK         8'h3b
// Peripheral enable field positions
`define BIT_EN_SDO         0
`define BIT_EN_LOGIC       1
`define BIT_EN_OSC         2
// Reset values
`define RST_DIRECTION      6'h3f
`define RST_LATCH          6'h00
`define RST_ANALOG         6'h3f
`define RST_STEERING       8'h00
`define RST_PERIPH_ENABLE  3'h0
// Line 3 is input only
`define INPUT_ONLY_LINE    3
// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// [rtl/port_a_io.v]
// Function
// - Port has direction, pin-level and output latch registers.
// - Enabled peripheral drives its line (port A only while direction is zero); the line stays readable.
// - Writing pin-level register writes the output latch, like latch writes.
// - Latch read returns latch; pin-level read returns real pin levels.
// - Analog-select bit disables the line's digital input buffer.
// - Steering bit 5: serial out on A4 if set, else C2.
// - Steering bit 4: slave select from A3 if set, else C3.
// - Steering bit 3: timer gate from A3 if set, else A4.
// - Steering bit 1: logic cell out on C5 if set, else A2.
// - Steering bit 0: oscillator out on A4 if set, else C1.
// - Steering bits 7, 6 and 2 ignore writes and read zero.
// - Steering changes never alter direction registers.
// - Peripheral overrides go to the selected pin only.
// - Port A is six lines, five of them bidirectional.
// - Direction one disables driver; zero drives the latch value.
// - Line 3 is input only; its direction bit reads one.
// - Port writes store the written value directly into the output latch.
// - Analog lines read zero on pin-level reads and timer gate; slave select sees raw A3.
// - Highest priority enabled output function drives a shared pin.
`timescale 1ns/1ps
`include "port_a_io_map.vh"
`default_nettype none
module port_a_io #(
   parameter LINES = 6
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [11:0]       s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [11:0]       s_axi_araddr,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   input  wire [LINES-1:0]  port_a_in,
   output reg  [LINES-1:0]  port_a_out,
   output reg  [LINES-1:0]  port_a_oe,
   input  wire              port_c_line3_in,
   output reg               port_c_line1_out,
   output reg               port_c_line1_oe,
   output reg               port_c_line2_out,
   output reg               port_c_line2_oe,
   output reg               port_c_line5_out,
   output reg               port_c_line5_oe,
   output reg  [LINES-1:0]  port_a_input_enable,
   input  wire              serial_data_out,
   input  wire              logic_cell_output,
   input  wire              oscillator_output,
   output reg               slave_select_in,
   output reg               timer_gate_input
);
   // Control registers
   reg [LINES-1:0] port_a_output_latch;
   reg [LINES-1:0] port_a_direction;
   reg [LINES-1:0] port_a_analog_select;
   reg [7:0]       alternate_pin_steering;
   reg [2:0]       periph_enable;
   // Pin synchronisers
   reg [LINES-1:0] pin_meta;
   reg [LINES-1:0] pin_sync;
   reg             c3_meta;
   reg             c3_sync;
   // Write channel holding
   reg             aw_held;
   reg             w_held;
   reg [11:0]      aw_addr;
   reg [31:0]      w_data;
   reg [3:0]       w_strb;
   // Combinational
   reg [LINES-1:0] digital_read;
   reg [LINES-1:0] next_out;
   reg [LINES-1:0] next_oe;
   reg [31:0]      next_rdata;
   reg             next_rerr;
   wire            do_write;
   wire            lane0;

   // Two flip-flop synchronisers for pin inputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta <= {LINES{1'b0}};
         pin_sync <= {LINES{1'b0}};
         c3_meta  <= 1'b0;
         c3_sync  <= 1'b0;
      end else begin
         pin_meta <= port_a_in;
         pin_sync <= pin_meta;
         // Slave select alternative on port C
         c3_meta  <= port_c_line3_in;
         c3_sync  <= c3_meta;
      end
   end

   // Digital read path; analog lines read zero
   always @* begin
      digital_read = pin_sync & ~port_a_analog_select;
   end

   // Pin drive: peripheral priority over latch on selected pin
   always @* begin
      next_out = port_a_output_latch;
      next_oe  = ~port_a_direction;
      // A2: logic cell when steered here
      if (periph_enable[`BIT_EN_LOGIC] && !alternate_pin_steering[`BIT_LOGIC_SEL]) begin
         next_out[2] = logic_cell_output;
      end
      // A4: oscillator above serial out above latch
      if (periph_enable[`BIT_EN_OSC] && alternate_pin_steering[`BIT_OSC_SEL]) begin
         next_out[4] = oscillator_output;
      end else if (periph_enable[`BIT_EN_SDO] && alternate_pin_steering[`BIT_SDO_SEL]) begin
         next_out[4] = serial_data_out;
      end
      // Line 3 has no output driver
      next_oe[`INPUT_ONLY_LINE]  = 1'b0;
      next_out[`INPUT_ONLY_LINE] = 1'b0;
   end

   // Registered port A drive
   always @(posedge aclk) begin
      if (!aresetn) begin
         port_a_out <= {LINES{1'b0}};
         port_a_oe  <= {LINES{1'b0}};
      end else begin
         port_a_out <= next_out;
         port_a_oe  <= next_oe;
      end
   end

   // Port C alternatives driven only while their function is steered there
   always @(posedge aclk) begin
      if (!aresetn) begin
         port_c_line1_out <= 1'b0;
         port_c_line1_oe  <= 1'b0;
         port_c_line2_out <= 1'b0;
         port_c_line2_oe  <= 1'b0;
         port_c_line5_out <= 1'b0;
         port_c_line5_oe  <= 1'b0;
      end else begin
         port_c_line1_out <= oscillator_output;
         port_c_line1_oe  <= periph_enable[`BIT_EN_OSC] &
                             ~alternate_pin_steering[`BIT_OSC_SEL];
         port_c_line2_out <= serial_data_out;
         port_c_line2_oe  <= periph_enable[`BIT_EN_SDO] &
                             ~alternate_pin_steering[`BIT_SDO_SEL];
         port_c_line5_out <= logic_cell_output;
         port_c_line5_oe  <= periph_enable[`BIT_EN_LOGIC] &
                             alternate_pin_steering[`BIT_LOGIC_SEL];
      end
   end

   // Steered peripheral inputs and input buffer enables
   always @(posedge aclk) begin
      if (!aresetn) begin
         port_a_input_enable <= {LINES{1'b0}};
         slave_select_in     <= 1'b1;             // Idle, deselected
         timer_gate_input    <= 1'b0;
      end else begin
         port_a_input_enable <= ~port_a_analog_select;
         // Raw line 3 level; timer gate honours the analog mask
         slave_select_in     <= alternate_pin_steering[`BIT_SS_SEL] ?
                                pin_sync[3] : c3_sync;
         timer_gate_input    <= alternate_pin_steering[`BIT_TGATE_SEL] ?
                                digital_read[3] : digital_read[4];
      end
   end

   // Address decode shared by write response and read error
   function mapped;
      input [11:0] addr;
      begin
         case (addr)
            `OFF_PIN_LEVELS,
            `OFF_OUTPUT_LATCH,
            `OFF_DIRECTION,
            `OFF_ANALOG_SELECT,
            `OFF_STEERING,
            `OFF_PERIPH_ENABLE: mapped = 1'b1;
            default:            mapped = 1'b0;
         endcase
      end
   endfunction

   // AXI write address and data capture, either order
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign lane0    = w_strb[0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 12'h000;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end else begin
         // Each ready is a one-cycle pulse, blocked while its item is held
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Unmapped addresses answer with an error and change nothing
            s_axi_bresp  <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register file updates on the response edge
   always @(posedge aclk) begin
      if (!aresetn) begin
         port_a_output_latch    <= `RST_LATCH;
         port_a_direction       <= `RST_DIRECTION;
         port_a_analog_select   <= `RST_ANALOG;
         alternate_pin_steering <= `RST_STEERING;
         periph_enable          <= `RST_PERIPH_ENABLE;
      end else if (do_write && lane0) begin
         case (aw_addr)
            // Pin-level and latch writes both land in the latch
            `OFF_PIN_LEVELS, `OFF_OUTPUT_LATCH:
               port_a_output_latch <= w_data[LINES-1:0];
            // Line 3 direction is forced to input
            `OFF_DIRECTION: begin
               port_a_direction <= w_data[LINES-1:0] |
                                   (6'h01 << `INPUT_ONLY_LINE);
            end
            // Analog select also gates the digital reads
            `OFF_ANALOG_SELECT:
               port_a_analog_select <= w_data[LINES-1:0];
            // Steering write touches only the steering bits
            `OFF_STEERING:
               alternate_pin_steering <= w_data[7:0] & `STEER_MASK;
            // Enables for serial out, logic cell and oscillator
            `OFF_PERIPH_ENABLE:
               periph_enable <= w_data[2:0];
            default: begin
            end
         endcase
      end
   end

   // Read data mux
   always @* begin
      next_rdata = 32'h00000000;
      next_rerr  = !mapped(s_axi_araddr);
      case (s_axi_araddr)
         `OFF_PIN_LEVELS:    next_rdata[LINES-1:0] = digital_read;
         `OFF_OUTPUT_LATCH:  next_rdata[LINES-1:0] = port_a_output_latch;
         `OFF_DIRECTION:     next_rdata[LINES-1:0] = port_a_direction;
         `OFF_ANALOG_SELECT: next_rdata[LINES-1:0] = port_a_analog_select;
         `OFF_STEERING:      next_rdata[7:0] = alternate_pin_steering;
         `OFF_PERIPH_ENABLE: next_rdata[2:0] = periph_enable;
         default:            next_rdata = 32'h00000000;
      endcase
   end

   // AXI read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         // One address at a time, none while an answer waits
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_model (
   input  wire logic [5:0] drive,
   input  wire logic [5:0] enable,
   input  wire logic [5:0] ext,
   output logic      [5:0] level
);
   // A driven line shows its driver, a released line the outside level
   assign level = (drive & enable) | (ext & ~enable);
endmodule
`default_nettype wire

// [tb/port_a_io_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module port_a_io_asserts #(
   parameter LINES = 6
) (
   input wire logic             aclk,
   input wire logic             aresetn,
   input wire logic             s_axi_awready,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic [1:0]       s_axi_bresp,
   input wire logic             s_axi_arready,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   input wire logic [31:0]      s_axi_rdata,
   input wire logic [LINES-1:0] port_a_oe,
   input wire logic             port_c_line1_out,
   input wire logic             port_c_line1_oe,
   input wire logic             port_c_line2_out,
   input wire logic             port_c_line2_oe,
   input wire logic             port_c_line5_out,
   input wire logic             port_c_line5_oe,
   input wire logic             serial_data_out,
   input wire logic             logic_cell_output,
   input wire logic             oscillator_output
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Pin driver and alternate pin relations
   property p_oe3; port_a_oe[3] == 1'b0; endproperty
   a_oe3: assert property (p_oe3) else $error("input only line driven");
   property p_c1; port_c_line1_oe |-> port_c_line1_out == $past(oscillator_output); endproperty
   a_c1: assert property (p_c1) else $error("line c1 value wrong");
   property p_c2; port_c_line2_oe |-> port_c_line2_out == $past(serial_data_out); endproperty
   a_c2: assert property (p_c2) else $error("line c2 value wrong");
   property p_c5; port_c_line5_oe |-> port_c_line5_out == $past(logic_cell_output); endproperty
   a_c5: assert property (p_c5) else $error("line c5 value wrong");
   // Bus answer timing and holding
   property p_bwait; s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
   a_bwait: assert property (p_bwait) else $error("write answer late");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rlat; s_axi_arready |=> s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   c_c1: cover property (port_c_line1_oe);
   c_c5: cover property (port_c_line5_oe);
   c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
`default_nettype wire

// [tb/tb_port_a_io.sv]
`timescale 1ns/1ps
`default_nettype none
`include "port_a_io_map.vh"
module tb_port_a_io;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [5:0]  port_a_out, port_a_oe, port_a_in, port_a_input_enable, ext = 6'h00;
   logic        port_c_line3_in = 1'b0, serial_data_out = 1'b0, logic_cell_output = 1'b0;
   logic        oscillator_output = 1'b0, slave_select_in, timer_gate_input;
   logic        port_c_line1_out, port_c_line1_oe, port_c_line2_out, port_c_line2_oe;
   logic        port_c_line5_out, port_c_line5_oe;
   int          err_total = 0, num_checks = 0;
   always #2.5 aclk = ~aclk;
   port_a_io port_a_io_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_in, .port_a_out,
      .port_a_oe, .port_c_line3_in, .port_c_line1_out, .port_c_line1_oe, .port_c_line2_out,
      .port_c_line2_oe, .port_c_line5_out, .port_c_line5_oe, .port_a_input_enable,
      .serial_data_out, .logic_cell_output, .oscillator_output, .slave_select_in,
      .timer_gate_input);
   pin_model pin_model_inst (.drive(port_a_out), .enable(port_a_oe), .ext, .level(port_a_in));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Write with both channels offered together, each released when taken;
   // starts one edge on so bready is never lowered and raised in one step
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask
   task automatic t_reset;
      rd(`OFF_DIRECTION, 32'h3f, `RESP_OKAY);
      rd(`OFF_OUTPUT_LATCH, 32'h00, `RESP_OKAY);
      rd(`OFF_ANALOG_SELECT, 32'h3f, `RESP_OKAY);
      rd(`OFF_STEERING, 32'h00, `RESP_OKAY);
      chk("oe", 32'h0, {26'h0, port_a_oe});
   endtask
   task automatic t_port;
      wr(`OFF_ANALOG_SELECT, 32'h0, `RESP_OKAY);
      wr(`OFF_DIRECTION, 32'h0, `RESP_OKAY);
      rd(`OFF_DIRECTION, 32'h08, `RESP_OKAY);
      wr(`OFF_PIN_LEVELS, 32'h15, `RESP_OKAY);
      ext <= 6'h08;
      rd(`OFF_OUTPUT_LATCH, 32'h15, `RESP_OKAY);
      chk("oe", 32'h37, {26'h0, port_a_oe});
      rd(`OFF_PIN_LEVELS, 32'h1d, `RESP_OKAY);
      wr(`OFF_DIRECTION, 32'h3f, `RESP_OKAY);
      ext <= 6'h2a;
      rd(`OFF_OUTPUT_LATCH, 32'h15, `RESP_OKAY);
      rd(`OFF_PIN_LEVELS, 32'h2a, `RESP_OKAY);
      wr(`OFF_ANALOG_SELECT, 32'h02, `RESP_OKAY);
      rd(`OFF_PIN_LEVELS, 32'h28, `RESP_OKAY);
      chk("input_enable", 32'h3d, {26'h0, port_a_input_enable});
   endtask
   task automatic t_steer;
      wr(`OFF_ANALOG_SELECT, 32'h0, `RESP_OKAY);
      wr(`OFF_DIRECTION, 32'h0, `RESP_OKAY);
      serial_data_out <= 1'b1;
      wr(`OFF_PERIPH_ENABLE, 32'h7, `RESP_OKAY);
      wr(`OFF_STEERING, 32'hff, `RESP_OKAY);
      rd(`OFF_STEERING, 32'h3b, `RESP_OKAY);
      rd(`OFF_DIRECTION, 32'h08, `RESP_OKAY);
      chk("a4", 32'h0, {31'h0, port_a_out[4]});
      chk("c1_oe c2_oe", 32'h0, {30'h0, port_c_line1_oe, port_c_line2_oe});
      chk("c5 a2", 32'h3, {30'h0, port_c_line5_oe, port_a_out[2]});
      chk("ss tg", 32'h3, {30'h0, slave_select_in, timer_gate_input});
      oscillator_output <= 1'b1;
      wr(`OFF_OUTPUT_LATCH, 32'h05, `RESP_OKAY);
      wr(`OFF_STEERING, 32'h00, `RESP_OKAY);
      rd(`OFF_OUTPUT_LATCH, 32'h05, `RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk("c1", 32'h3, {30'h0, port_c_line1_oe, port_c_line1_out});
      chk("c2", 32'h3, {30'h0, port_c_line2_oe, port_c_line2_out});
      chk("c5 a2", 32'h0, {30'h0, port_c_line5_oe, port_a_out[2]});
      chk("a4", 32'h0, {31'h0, port_a_out[4]});
      chk("ss tg", 32'h0, {30'h0, slave_select_in, timer_gate_input});
   endtask
   task automatic t_bad;
      wr(12'h100, 32'h1, `RESP_SLVERR);
      rd(12'h100, 32'h0, `RESP_SLVERR);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset;
      t_port;
      t_steer;
      t_bad;
      results;
   end
   // Cuts a hung bus wait short
   initial begin
      repeat (5000) @(posedge aclk);
      err_total++;
      results;
   end
endmodule
bind port_a_io port_a_io_asserts #(.LINES(LINES)) port_a_io_asserts_inst (.aclk, .aresetn,
   .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port_a_oe,
   .port_c_line1_out, .port_c_line1_oe, .port_c_line2_out, .port_c_line2_oe,
   .port_c_line5_out, .port_c_line5_oe, .serial_data_out, .logic_cell_output,
   .oscillator_output);
`default_nettype wire
